// ===== mbd_classify.sv
`timescale 1ns/1ps
module mbd_classify
  import mbd_pkg::*;
(
  mbd_dec_if.classifier dif
);

  logic [7:0] upper;

  assign upper = dif.word[BYTE_HI:BYTE_LO];

  // --------------------------------------------------------------
  // Opcode match: full words first, then masked forms, then bytes
  // --------------------------------------------------------------
  always_comb
  begin
    dif.op = OP_NONE;
    if (dif.word == W_ADD_PROD) dif.op = OP_ADD_PRODUCT_TO_ACC;
    else if (dif.word == W_PROD_ACC) dif.op = OP_PRODUCT_TO_ACC;
    else if (dif.word == W_SUB_PROD) dif.op = OP_SUB_PRODUCT_FROM_ACC;
    else if ((dif.word & M_SHIFT) == W_SHIFT) dif.op = OP_SET_PRODUCT_SHIFT;
    else if ((dif.word & M_VIA_ACC) == W_VIA_ACC) dif.op = OP_BRANCH_VIA_ACC;
    else if ((dif.word & M_BRANCH) == W_BRANCH) dif.op = OP_BRANCH_ALWAYS;
    else if ((dif.word & M_BRANCH) == W_AUX_NZ) dif.op = OP_BRANCH_AUX_NONZERO;
    else if ((dif.word & M_BRANCH) == W_TEST_SET) dif.op = OP_BRANCH_TESTFLAG_SET;
    else if (dif.word[BYTE_HI -: 3] == TOP_IMM) dif.op = OP_MULTIPLY_IMMEDIATE;
    else
    begin
      case (upper)
        U_PROD_HI: dif.op = OP_LOAD_PRODUCT_HIGH;
        U_LD_MULT: dif.op = OP_LOAD_MULTIPLICAND;
        U_LD_ACCUM: dif.op = OP_LOAD_MULTIPLICAND_ACCUMULATE;
        U_LD_MOVE: dif.op = OP_LOAD_MULTIPLICAND_MOVE;
        U_LD_PROD: dif.op = OP_LOAD_MULTIPLICAND_PRODUCT_TO_ACC;
        U_LD_SUB: dif.op = OP_LOAD_MULTIPLICAND_SUBTRACT;
        U_MAC_LONG: dif.op = OP_MULTIPLY_ACCUMULATE_LONG;
        U_MAC_MOVE: dif.op = OP_MULTIPLY_ACCUMULATE_MOVE;
        U_MULT: dif.op = OP_MULTIPLY_OPERAND;
        U_MULT_ADD: dif.op = OP_MULTIPLY_ADD_PREVIOUS;
        U_MULT_SUB: dif.op = OP_MULTIPLY_SUB_PREVIOUS;
        U_MULT_UNS: dif.op = OP_MULTIPLY_UNSIGNED;
        U_ST_HI: dif.op = OP_STORE_PRODUCT_HIGH;
        U_ST_LO: dif.op = OP_STORE_PRODUCT_LOW;
        U_SQ_ACC: dif.op = OP_SQUARE_ACCUMULATE;
        U_SQ_SUB: dif.op = OP_SQUARE_SUBTRACT;
        default: dif.op = OP_NONE;
      endcase
    end
  end

  always_comb
  begin
    dif.two_word = 1'b0;
    dif.is_branch = 1'b0;
    dif.mem_operand = 1'b0;
    case (dif.op)
      OP_MULTIPLY_ACCUMULATE_LONG, OP_MULTIPLY_ACCUMULATE_MOVE:
      begin
        dif.two_word = 1'b1;
        dif.mem_operand = 1'b1;
      end
      OP_BRANCH_ALWAYS, OP_BRANCH_AUX_NONZERO, OP_BRANCH_TESTFLAG_SET:
      begin
        dif.two_word = 1'b1;
        dif.is_branch = 1'b1;
      end
      OP_BRANCH_VIA_ACC: dif.is_branch = 1'b1;
      OP_NONE, OP_ADD_PRODUCT_TO_ACC, OP_PRODUCT_TO_ACC, OP_SUB_PRODUCT_FROM_ACC,
      OP_SET_PRODUCT_SHIFT, OP_MULTIPLY_IMMEDIATE: dif.mem_operand = 1'b0;
      default: dif.mem_operand = 1'b1;
    endcase
  end

endmodule

// ===== mbd_dec_if.sv
`timescale 1ns/1ps
interface mbd_dec_if;
  import mbd_pkg::*;
  logic [15:0] word;
  mbd_op_e op;
  logic two_word;
  logic mem_operand;
  logic is_branch;

  modport classifier (input word, output op, output two_word, output mem_operand,
    output is_branch);
  modport user (output word, input op, input two_word, input mem_operand, input is_branch);
endinterface

// ===== mbd_decoder.sv
`timescale 1ns/1ps
module mbd_decoder
  import mbd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic flush,
  input wire logic [15:0] acc_low,
  input wire logic aux_nonzero,
  input wire logic test_control_flag,
  output logic dec_valid,
  output mbd_op_e dec_op,
  output logic dec_unknown,
  output logic dec_mem_operand,
  output logic dec_indirect,
  output logic [6:0] dec_offset,
  output logic [12:0] dec_imm,
  output logic [15:0] dec_ext_word,
  output logic [1:0] product_shift_field,
  output logic ctl_acc_add,
  output logic ctl_acc_sub,
  output logic ctl_acc_load,
  output logic ctl_mult_load,
  output logic ctl_mult_run,
  output logic ctl_unsigned,
  output logic ctl_square,
  output logic ctl_prod_high_load,
  output logic ctl_store_high,
  output logic ctl_store_low,
  output logic ctl_data_move,
  output logic branch_valid,
  output logic branch_taken,
  output logic [15:0] branch_target,
  output logic [6:0] branch_ar_ctrl,
  output logic second_pending
);

  // --------------------------------------------------------------
  // Classification of the word on the fetch port
  // --------------------------------------------------------------
  mbd_dec_if dif ();

  mbd_classify u_classify (
    .dif(dif)
  );

  assign dif.word = fetch_word;

  // --------------------------------------------------------------
  // Control strobes per operation
  // --------------------------------------------------------------
  function automatic mbd_ctl_s ctl_of(input mbd_op_e op);
    mbd_ctl_s c;
    c = '0;
    case (op)
      OP_ADD_PRODUCT_TO_ACC: c.acc_add = 1'b1;
      OP_PRODUCT_TO_ACC: c.acc_load = 1'b1;
      OP_SUB_PRODUCT_FROM_ACC: c.acc_sub = 1'b1;
      OP_LOAD_PRODUCT_HIGH: c.prod_high_load = 1'b1;
      OP_LOAD_MULTIPLICAND: c.mult_load = 1'b1;
      OP_LOAD_MULTIPLICAND_ACCUMULATE:
      begin
        c.mult_load = 1'b1;
        c.acc_add = 1'b1;
      end
      OP_LOAD_MULTIPLICAND_MOVE:
      begin
        c.mult_load = 1'b1;
        c.acc_add = 1'b1;
        c.data_move = 1'b1;
      end
      OP_LOAD_MULTIPLICAND_PRODUCT_TO_ACC:
      begin
        c.mult_load = 1'b1;
        c.acc_load = 1'b1;
      end
      OP_LOAD_MULTIPLICAND_SUBTRACT:
      begin
        c.mult_load = 1'b1;
        c.acc_sub = 1'b1;
      end
      OP_MULTIPLY_ACCUMULATE_LONG:
      begin
        c.mult_load = 1'b1;
        c.mult_run = 1'b1;
        c.acc_add = 1'b1;
      end
      OP_MULTIPLY_ACCUMULATE_MOVE:
      begin
        c.mult_load = 1'b1;
        c.mult_run = 1'b1;
        c.acc_add = 1'b1;
        c.data_move = 1'b1;
      end
      OP_MULTIPLY_OPERAND, OP_MULTIPLY_IMMEDIATE: c.mult_run = 1'b1;
      OP_MULTIPLY_ADD_PREVIOUS:
      begin
        c.mult_run = 1'b1;
        c.acc_add = 1'b1;
      end
      OP_MULTIPLY_SUB_PREVIOUS:
      begin
        c.mult_run = 1'b1;
        c.acc_sub = 1'b1;
      end
      OP_MULTIPLY_UNSIGNED:
      begin
        c.mult_run = 1'b1;
        c.unsigned_mul = 1'b1;
      end
      OP_STORE_PRODUCT_HIGH: c.store_high = 1'b1;
      OP_STORE_PRODUCT_LOW: c.store_low = 1'b1;
      OP_SQUARE_ACCUMULATE:
      begin
        c.square = 1'b1;
        c.mult_run = 1'b1;
        c.acc_add = 1'b1;
      end
      OP_SQUARE_SUBTRACT:
      begin
        c.square = 1'b1;
        c.mult_run = 1'b1;
        c.acc_sub = 1'b1;
      end
      default: c = '0;
    endcase
    return c;
  endfunction

  // --------------------------------------------------------------
  // Sequencing of one- and two-word instructions
  // --------------------------------------------------------------
  mbd_state_e state_r;
  mbd_op_e first_op_r;
  logic [15:0] first_word_r;
  logic take_first;
  logic take_second;
  mbd_ctl_s ctl_r;

  // A flushed cycle drops both a pending first word and the word on the port
  assign take_first = fetch_valid && !flush && (state_r == S_IDLE);
  assign take_second = fetch_valid && !flush && (state_r == S_WAIT);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_r <= S_IDLE;
    else
    begin
      case (state_r)
        S_IDLE:
          if (take_first && dif.two_word)
            state_r <= S_WAIT;
        S_WAIT:
          if (flush || take_second)
            state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      first_op_r <= OP_NONE;
      first_word_r <= '0;
    end
    else if (take_first && dif.two_word)
    begin
      first_op_r <= dif.op;
      first_word_r <= fetch_word;
    end
  end

  assign second_pending = (state_r == S_WAIT);

  // --------------------------------------------------------------
  // Decoded instruction outputs
  // --------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dec_valid <= 1'b0;
      dec_op <= OP_NONE;
      dec_unknown <= 1'b0;
      dec_mem_operand <= 1'b0;
      dec_indirect <= 1'b0;
      dec_offset <= '0;
      dec_imm <= '0;
      dec_ext_word <= '0;
      ctl_r <= '0;
    end
    else if (take_first && !dif.two_word)
    begin
      dec_valid <= 1'b1;
      dec_op <= dif.op;
      dec_unknown <= (dif.op == OP_NONE);
      dec_mem_operand <= dif.mem_operand;
      dec_indirect <= dif.mem_operand && fetch_word[MODE_BIT];
      dec_offset <= fetch_word[FIELD7_MSB:0];
      dec_imm <= fetch_word[IMM_MSB:0];
      dec_ext_word <= '0;
      ctl_r <= ctl_of(dif.op);
    end
    else if (take_second)
    begin
      dec_valid <= 1'b1;
      dec_op <= first_op_r;
      dec_unknown <= 1'b0;
      dec_mem_operand <= (first_op_r == OP_MULTIPLY_ACCUMULATE_LONG) ||
        (first_op_r == OP_MULTIPLY_ACCUMULATE_MOVE);
      dec_indirect <= first_word_r[MODE_BIT] &&
        (first_op_r inside {OP_MULTIPLY_ACCUMULATE_LONG, OP_MULTIPLY_ACCUMULATE_MOVE});
      dec_offset <= first_word_r[FIELD7_MSB:0];
      dec_imm <= '0;
      dec_ext_word <= fetch_word;
      ctl_r <= ctl_of(first_op_r);
    end
    else
    begin
      dec_valid <= 1'b0;
      ctl_r <= '0;
    end
  end

  assign ctl_acc_add = ctl_r.acc_add;
  assign ctl_acc_sub = ctl_r.acc_sub;
  assign ctl_acc_load = ctl_r.acc_load;
  assign ctl_mult_load = ctl_r.mult_load;
  assign ctl_mult_run = ctl_r.mult_run;
  assign ctl_unsigned = ctl_r.unsigned_mul;
  assign ctl_square = ctl_r.square;
  assign ctl_prod_high_load = ctl_r.prod_high_load;
  assign ctl_store_high = ctl_r.store_high;
  assign ctl_store_low = ctl_r.store_low;
  assign ctl_data_move = ctl_r.data_move;

  // --------------------------------------------------------------
  // Product shift mode, held until the next set instruction
  // --------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      product_shift_field <= SHIFT_RESET;
    else if (take_first && dif.op == OP_SET_PRODUCT_SHIFT)
      product_shift_field <= fetch_word[SHIFT_MSB:0];
  end

  // --------------------------------------------------------------
  // Branch resolution
  // --------------------------------------------------------------
  // Conditions are sampled with the second word so the pipeline sees the
  // status as it stands when the target becomes known.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      branch_valid <= 1'b0;
      branch_taken <= 1'b0;
      branch_target <= '0;
      branch_ar_ctrl <= '0;
    end
    else if (take_first && dif.is_branch && !dif.two_word)
    begin
      branch_valid <= 1'b1;
      branch_taken <= 1'b1;
      branch_target <= acc_low;
      branch_ar_ctrl <= '0;
    end
    else if (take_second && first_op_r == OP_BRANCH_ALWAYS)
    begin
      branch_valid <= 1'b1;
      branch_taken <= 1'b1;
      branch_target <= fetch_word;
      branch_ar_ctrl <= first_word_r[FIELD7_MSB:0];
    end
    else if (take_second && first_op_r == OP_BRANCH_AUX_NONZERO)
    begin
      branch_valid <= 1'b1;
      branch_taken <= aux_nonzero;
      branch_target <= fetch_word;
      branch_ar_ctrl <= first_word_r[FIELD7_MSB:0];
    end
    else if (take_second && first_op_r == OP_BRANCH_TESTFLAG_SET)
    begin
      branch_valid <= 1'b1;
      branch_taken <= test_control_flag;
      branch_target <= fetch_word;
      branch_ar_ctrl <= first_word_r[FIELD7_MSB:0];
    end
    else
    begin
      branch_valid <= 1'b0;
      branch_taken <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_add_prod;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word == W_ADD_PROD |=> dec_valid && ctl_acc_add && !ctl_acc_sub;
  endproperty
  a_add_prod: assert property (p_add_prod) else $error("add product not decoded");

  property p_prod_acc;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word == W_PROD_ACC |=> dec_op == OP_PRODUCT_TO_ACC && ctl_acc_load;
  endproperty
  a_prod_acc: assert property (p_prod_acc) else $error("product load not decoded");

  property p_sub_prod;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word == W_SUB_PROD |=> ctl_acc_sub && !ctl_acc_add;
  endproperty
  a_sub_prod: assert property (p_sub_prod) else $error("product subtract wrong");

  property p_ld_mult;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word[BYTE_HI:BYTE_LO] == U_LD_MULT |=> ctl_mult_load &&
      dec_indirect == $past(fetch_word[MODE_BIT]) && dec_offset == $past(fetch_word[FIELD7_MSB:0]);
  endproperty
  a_ld_mult: assert property (p_ld_mult) else $error("multiplicand load wrong");

  property p_two_word;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word[BYTE_HI:BYTE_LO] == U_MAC_LONG
      |=> !dec_valid && second_pending;
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word wait missing");

  property p_imm;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word[BYTE_HI -: 3] == TOP_IMM
      |=> ctl_mult_run && dec_imm == $past(fetch_word[IMM_MSB:0]);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate multiply wrong");

  property p_shift;
    @(posedge mclk) disable iff (rst)
    take_first && (fetch_word & M_SHIFT) == W_SHIFT
      |=> product_shift_field == $past(fetch_word[SHIFT_MSB:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift mode not set");

  property p_branch;
    @(posedge mclk) disable iff (rst)
    take_first && fetch_word == W_BRANCH ##1 take_second
      |=> branch_valid && branch_taken && branch_target == $past(fetch_word);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_via_acc;
    @(posedge mclk) disable iff (rst)
    take_first && (fetch_word & M_VIA_ACC) == W_VIA_ACC
      |=> branch_taken && branch_target == $past(acc_low);
  endproperty
  a_via_acc: assert property (p_via_acc) else $error("branch via acc wrong");

  property p_aux_nz;
    @(posedge mclk) disable iff (rst)
    take_second && first_op_r == OP_BRANCH_AUX_NONZERO
      |=> branch_valid && branch_taken == $past(aux_nonzero);
  endproperty
  a_aux_nz: assert property (p_aux_nz) else $error("aux branch condition wrong");

  property p_test_set;
    @(posedge mclk) disable iff (rst)
    take_second && first_op_r == OP_BRANCH_TESTFLAG_SET
      |=> branch_taken == $past(test_control_flag);
  endproperty
  a_test_set: assert property (p_test_set) else $error("test branch condition wrong");

  property p_ar_ctrl;
    @(posedge mclk) disable iff (rst)
    take_second && first_op_r == OP_BRANCH_ALWAYS
      |=> branch_ar_ctrl == $past(first_word_r[FIELD7_MSB:0]);
  endproperty
  a_ar_ctrl: assert property (p_ar_ctrl) else $error("branch aux control wrong");

endmodule

// ===== mbd_pkg.sv
package mbd_pkg;

  localparam int WORD_W = 16;
  localparam int BYTE_HI = 15;
  localparam int BYTE_LO = 8;
  localparam int MODE_BIT = 7;
  localparam int FIELD7_MSB = 6;
  localparam int IMM_MSB = 12;
  localparam int SHIFT_MSB = 1;

  localparam logic [15:0] W_ADD_PROD = 16'hce15;
  localparam logic [15:0] W_PROD_ACC = 16'hce14;
  localparam logic [15:0] W_SUB_PROD = 16'hce16;
  localparam logic [15:0] M_SHIFT = 16'hfffc;
  localparam logic [15:0] W_SHIFT = 16'hce08;
  localparam logic [15:0] M_VIA_ACC = 16'hfff8;
  localparam logic [15:0] W_VIA_ACC = 16'hce20;
  localparam logic [15:0] M_BRANCH = 16'hff80;
  localparam logic [15:0] W_BRANCH = 16'hff80;
  localparam logic [15:0] W_AUX_NZ = 16'hfb80;
  localparam logic [15:0] W_TEST_SET = 16'hf980;
  localparam logic [2:0] TOP_IMM = 3'h5;

  localparam logic [7:0] U_PROD_HI = 8'h53;
  localparam logic [7:0] U_LD_MULT = 8'h3c;
  localparam logic [7:0] U_LD_ACCUM = 8'h3d;
  localparam logic [7:0] U_LD_MOVE = 8'h3f;
  localparam logic [7:0] U_LD_PROD = 8'h3e;
  localparam logic [7:0] U_LD_SUB = 8'h5b;
  localparam logic [7:0] U_MAC_LONG = 8'h5d;
  localparam logic [7:0] U_MAC_MOVE = 8'h5c;
  localparam logic [7:0] U_MULT = 8'h38;
  localparam logic [7:0] U_MULT_ADD = 8'h3a;
  localparam logic [7:0] U_MULT_SUB = 8'h3b;
  localparam logic [7:0] U_MULT_UNS = 8'hcf;
  localparam logic [7:0] U_ST_HI = 8'h7d;
  localparam logic [7:0] U_ST_LO = 8'h7c;
  localparam logic [7:0] U_SQ_ACC = 8'h39;
  localparam logic [7:0] U_SQ_SUB = 8'h5a;

  localparam logic [1:0] SHIFT_RESET = 2'h0;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ADD_PRODUCT_TO_ACC = 5'h01, OP_PRODUCT_TO_ACC = 5'h02,
    OP_SUB_PRODUCT_FROM_ACC = 5'h03, OP_SET_PRODUCT_SHIFT = 5'h04,
    OP_BRANCH_VIA_ACC = 5'h05, OP_LOAD_PRODUCT_HIGH = 5'h06,
    OP_LOAD_MULTIPLICAND = 5'h07, OP_LOAD_MULTIPLICAND_ACCUMULATE = 5'h08,
    OP_LOAD_MULTIPLICAND_MOVE = 5'h09, OP_LOAD_MULTIPLICAND_PRODUCT_TO_ACC = 5'h0a,
    OP_LOAD_MULTIPLICAND_SUBTRACT = 5'h0b, OP_MULTIPLY_ACCUMULATE_LONG = 5'h0c,
    OP_MULTIPLY_ACCUMULATE_MOVE = 5'h0d, OP_MULTIPLY_OPERAND = 5'h0e,
    OP_MULTIPLY_IMMEDIATE = 5'h0f, OP_MULTIPLY_ADD_PREVIOUS = 5'h10,
    OP_MULTIPLY_SUB_PREVIOUS = 5'h11, OP_MULTIPLY_UNSIGNED = 5'h12,
    OP_STORE_PRODUCT_HIGH = 5'h13, OP_STORE_PRODUCT_LOW = 5'h14,
    OP_SQUARE_ACCUMULATE = 5'h15, OP_SQUARE_SUBTRACT = 5'h16,
    OP_BRANCH_ALWAYS = 5'h17, OP_BRANCH_AUX_NONZERO = 5'h18,
    OP_BRANCH_TESTFLAG_SET = 5'h19
  } mbd_op_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_WAIT = 2'b10
  } mbd_state_e;

  typedef struct packed {
    logic acc_add;
    logic acc_sub;
    logic acc_load;
    logic mult_load;
    logic mult_run;
    logic unsigned_mul;
    logic square;
    logic prod_high_load;
    logic store_high;
    logic store_low;
    logic data_move;
  } mbd_ctl_s;

endpackage

// ===== test_multiply_branch_opcode_decoder.sv
`timescale 1ns/1ps
module test_multiply_branch_opcode_decoder;
  import mbd_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic fetch_valid = 1'b0;
  logic [15:0] fetch_word = 16'h0000;
  logic flush = 1'b0;
  logic [15:0] acc_low = 16'h0000;
  logic aux_nonzero = 1'b0;
  logic test_control_flag = 1'b0;
  logic dec_valid, dec_unknown, dec_mem_operand, dec_indirect;
  mbd_op_e dec_op;
  logic [6:0] dec_offset, branch_ar_ctrl;
  logic [12:0] dec_imm;
  logic [15:0] dec_ext_word, branch_target;
  logic [1:0] product_shift_field;
  wire logic [10:0] ctl;
  logic branch_valid, branch_taken, second_pending;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  mbd_decoder mbd_decoder_i (.mclk(mclk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .flush(flush), .acc_low(acc_low), .aux_nonzero(aux_nonzero),
    .test_control_flag(test_control_flag), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_unknown(dec_unknown), .dec_mem_operand(dec_mem_operand),
    .dec_indirect(dec_indirect), .dec_offset(dec_offset), .dec_imm(dec_imm),
    .dec_ext_word(dec_ext_word), .product_shift_field(product_shift_field),
    .ctl_acc_add(ctl[10]), .ctl_acc_sub(ctl[9]), .ctl_acc_load(ctl[8]),
    .ctl_mult_load(ctl[7]), .ctl_mult_run(ctl[6]), .ctl_unsigned(ctl[5]),
    .ctl_square(ctl[4]), .ctl_prod_high_load(ctl[3]), .ctl_store_high(ctl[2]),
    .ctl_store_low(ctl[1]), .ctl_data_move(ctl[0]), .branch_valid(branch_valid),
    .branch_taken(branch_taken), .branch_target(branch_target),
    .branch_ar_ctrl(branch_ar_ctrl), .second_pending(second_pending));

  always #25 mclk = ~mclk;

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic [15:0] w);
    @(posedge mclk);
    fetch_valid <= 1'b1;
    fetch_word <= w;
  endtask

  // The edge that takes the last word; outputs are settled 1 ns later
  task automatic done_put;
    @(posedge mclk);
    fetch_valid <= 1'b0;
    flush <= 1'b0;
    #1;
  endtask

  task automatic single(input logic [15:0] w, input mbd_op_e op, input logic [10:0] m,
    input logic [10:0] e);
    put(w);
    done_put();
    chk(dec_valid, 1'b1, "dec_valid");
    chk(dec_op, op, "dec_op");
    chk(ctl & m, e, "ctl");
    chk(dec_unknown, op == OP_NONE, "dec_unknown");
    @(posedge mclk);
    #1;
    // Strobes stand for one cycle only
    chk({dec_valid, ctl}, 12'h000, "strobes off");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({dec_valid, branch_valid, second_pending, ctl}, 14'h0, "reset strobes");
    chk(dec_op, OP_NONE, "reset op");
    chk(product_shift_field, SHIFT_RESET, "reset shift");
  endtask

  task automatic t_product;
    single(16'hce15, OP_ADD_PRODUCT_TO_ACC, 11'h700, 11'h400);
    single(16'hce14, OP_PRODUCT_TO_ACC, 11'h700, 11'h100);
    single(16'hce16, OP_SUB_PRODUCT_FROM_ACC, 11'h700, 11'h200);
    single(16'h5385, OP_LOAD_PRODUCT_HIGH, 11'h008, 11'h008);
    single(16'h3c12, OP_LOAD_MULTIPLICAND, 11'h780, 11'h080);
    single(16'h3d00, OP_LOAD_MULTIPLICAND_ACCUMULATE, 11'h780, 11'h480);
    single(16'h3f7f, OP_LOAD_MULTIPLICAND_MOVE, 11'h781, 11'h481);
    single(16'h3e01, OP_LOAD_MULTIPLICAND_PRODUCT_TO_ACC, 11'h780, 11'h180);
    single(16'h5b02, OP_LOAD_MULTIPLICAND_SUBTRACT, 11'h780, 11'h280);
    single(16'h3803, OP_MULTIPLY_OPERAND, 11'h740, 11'h040);
    single(16'hb123, OP_MULTIPLY_IMMEDIATE, 11'h740, 11'h040);
    chk(dec_imm, 13'h1123, "dec_imm");
    single(16'h3a04, OP_MULTIPLY_ADD_PREVIOUS, 11'h740, 11'h440);
    single(16'h3b05, OP_MULTIPLY_SUB_PREVIOUS, 11'h740, 11'h240);
    single(16'hcf06, OP_MULTIPLY_UNSIGNED, 11'h760, 11'h060);
    single(16'h7d07, OP_STORE_PRODUCT_HIGH, 11'h006, 11'h004);
    single(16'h7c08, OP_STORE_PRODUCT_LOW, 11'h006, 11'h002);
    single(16'h3909, OP_SQUARE_ACCUMULATE, 11'h610, 11'h410);
    single(16'h5a0a, OP_SQUARE_SUBTRACT, 11'h610, 11'h210);
    // An unlisted word must not fire any datapath strobe
    single(16'h0000, OP_NONE, 11'h7ff, 11'h000);
  endtask

  task automatic t_shift;
    for (int i = 0; i < 4; i++)
    begin
      single(16'hce08 | i[15:0], OP_SET_PRODUCT_SHIFT, 11'h7ff, 11'h000);
      chk(product_shift_field, i[1:0], "shift field");
    end
  endtask

  task automatic t_addr;
    single(16'h3c85, OP_LOAD_MULTIPLICAND, 11'h780, 11'h080);
    chk({dec_mem_operand, dec_indirect, dec_offset}, 9'h185, "indirect");
    single(16'h3c12, OP_LOAD_MULTIPLICAND, 11'h780, 11'h080);
    chk({dec_mem_operand, dec_indirect, dec_offset}, 9'h112, "direct");
  endtask

  task automatic two(input logic [15:0] w1, input logic [15:0] w2, input mbd_op_e op);
    put(w1);
    done_put();
    chk({dec_valid, second_pending}, 2'b01, "first word wait");
    put(w2);
    done_put();
    chk({dec_valid, second_pending}, 2'b10, "second word done");
    chk(dec_op, op, "two-word op");
    chk(dec_ext_word, w2, "ext word");
  endtask

  task automatic t_long;
    two(16'h5d81, 16'h1234, OP_MULTIPLY_ACCUMULATE_LONG);
    chk({dec_mem_operand, dec_indirect, dec_offset}, 9'h181, "mac mode");
    chk(ctl & 11'h7c1, 11'h4c0, "mac ctl");
    two(16'h5c81, 16'h4321, OP_MULTIPLY_ACCUMULATE_MOVE);
    chk(ctl & 11'h7c1, 11'h4c1, "multiply_accumulate_move ctl");
  endtask

  task automatic br(input logic [15:0] w1, input logic [15:0] t, input logic tk);
    put(w1);
    put(t);
    done_put();
    chk({branch_valid, branch_taken}, {1'b1, tk}, "branch taken");
    chk(branch_target, t, "branch target");
    chk(branch_ar_ctrl, w1[6:0], "ar control");
    chk({dec_mem_operand, dec_indirect}, 2'b00, "branch mode");
  endtask

  task automatic t_branch;
    br(16'hff85, 16'habcd, 1'b1);
    chk(dec_op, OP_BRANCH_ALWAYS, "b op");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk);
      aux_nonzero <= i[0];
      test_control_flag <= ~i[0];
      br(16'hfb80 | i[15:0], 16'h0100, i[0]);
      chk(dec_op, OP_BRANCH_AUX_NONZERO, "aux op");
      br(16'hf9fe, 16'h0200, ~i[0]);
      chk(dec_op, OP_BRANCH_TESTFLAG_SET, "flag op");
    end
    @(posedge mclk);
    acc_low <= 16'h5a5a;
    put(16'hce25);
    done_put();
    chk({dec_op, branch_valid, branch_taken}, {OP_BRANCH_VIA_ACC, 2'b11}, "via acc");
    chk(branch_target, 16'h5a5a, "acc target");
    chk(branch_ar_ctrl, 7'h00, "acc ar");
  endtask

  task automatic t_flush;
    put(16'hff80);
    put(16'h7777);
    flush <= 1'b1;
    done_put();
    chk({dec_valid, branch_valid, second_pending}, 3'b000, "flushed");
    single(16'hce15, OP_ADD_PRODUCT_TO_ACC, 11'h700, 11'h400);
    chk(product_shift_field, 2'h3, "shift hold");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs about 120 cycles; the ceiling leaves ample margin
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      final_report();
    end
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    t_reset();
    @(posedge mclk);
    rst <= 1'b0;
    t_product();
    t_shift();
    t_addr();
    t_long();
    t_branch();
    t_flush();
    final_report();
  end
endmodule
